/* File: logic/fbn_pkg.sv */
// constants, types and carriers shared by the node status indicator design
// assumes a single 10 MHz system clock and active-low asynchronous reset
package fbn_pkg;

    // clock and base tick
    localparam int unsigned CLK_HZ            = 10_000_000;       // system clock rate
    localparam int unsigned TICK_MS           = 1;                // base tick period, ms
    localparam int unsigned TICK_CYCLES_DFLT  = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_W            = 16;               // tick prescaler width

    // lamp timing in ms, and the last red pulse index
    localparam logic [11:0] FLICKER_HALF_MS   = 12'h032;          // 50 ms, ~10 hz flicker
    localparam logic [11:0] FLASH_ON_MS       = 12'h0c8;          // 200 ms flash pulse
    localparam logic [11:0] FLASH_GAP_MS      = 12'h0c8;          // 200 ms between flashes
    localparam logic [11:0] FLASH_TAIL_MS     = 12'h3e8;          // 1000 ms after last flash
    localparam logic [11:0] BLINK_HALF_MS     = 12'h0c8;          // 200 ms, 2.5 hz blink
    localparam logic [11:0] ACT_HOLD_MS       = 12'h064;          // traffic keeps blink alive
    localparam logic [11:0] ACT_HALF_MS       = 12'h032;          // link lamp blink half period
    localparam logic [11:0] RED_SHORT_MS      = 12'h096;          // 150 ms red pulse
    localparam logic [11:0] RED_LONG_MS       = 12'h258;          // 600 ms red pulse
    localparam logic [11:0] RED_GAP_MS        = 12'h096;          // off time between pulses
    localparam logic [11:0] RED_PAUSE_MS      = 12'h7d0;          // 2 s pause between repeats
    localparam logic [2:0]  RED_LAST_IDX      = 3'h3;             // four pulses per code

    // node number range
    localparam logic [7:0]  NODE_ID_MAX       = 8'hef;            // 239

    // node management states
    typedef enum logic [2:0] {
        ST_NOT_ACTIVE = 3'h0,
        ST_BASIC_ETH  = 3'h1,
        ST_PREOP1     = 3'h2,
        ST_PREOP2     = 3'h3,
        ST_READY      = 3'h4,
        ST_OPER       = 3'h5,
        ST_STOPPED    = 3'h6
    } nmt_state_e;

    // commands from the managing node
    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_READY     = 3'h1,
        CMD_START     = 3'h2,
        CMD_STOP      = 3'h3,
        CMD_PREOP2    = 3'h4,
        CMD_RESET     = 3'h5
    } nmt_cmd_e;

    // decoded command carrier
    typedef struct packed {
        logic     valid;
        nmt_cmd_e cmd;
    } nmt_cmd_s;

    // lamp outputs carrier
    typedef struct packed {
        logic [1:0] link;      // bit 0 port a, bit 1 port b
        logic       green;
        logic       red;
        logic       fault;
    } lamp_s;

    // red error sequencer state
    typedef struct packed {
        logic        active;
        logic        code;     // 0 bus defect, 1 bad node number
        logic [2:0]  idx;
        logic        on;
        logic [11:0] cnt;
        logic        red;
    } red_st_s;

    // main module state
    typedef struct packed {
        nmt_state_e       nmt;
        logic [TICK_W-1:0] tick_cnt;
        logic             tick;
        logic [11:0]      g_cnt;
        logic [15:0]      na_cnt;
        logic [1:0][11:0] act_cnt;
        logic [1:0][11:0] ph_cnt;
        lamp_s            lamp;
        logic             pdo_tx;
        logic             pdo_rx;
    } top_st_s;

endpackage

/* File: logic/red_code_seq.sv */
// red error code sequencer: four timed pulses, then a long pause, repeated
// assumes a one-cycle ms tick from the parent and level error inputs
`timescale 1ns/10ps
module red_code_seq
    import fbn_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_b_i,
    // timing and error causes
    input  wire logic tick_i,
    input  wire logic bus_defect_i,
    input  wire logic node_bad_i,
    // pattern out
    output logic      red_o,
    output logic      busy_o
);

    red_st_s s_q;       // registered state
    red_st_s s_d;       // next state

    // pulse length by code and pulse index
    function automatic logic [11:0] on_time(input logic code, input logic [2:0] idx);
        logic first;
        first = (idx == 3'h0);
        if (!code) begin
            on_time = first ? RED_LONG_MS : RED_SHORT_MS;
        end else begin
            on_time = first ? RED_SHORT_MS : RED_LONG_MS;
        end
    endfunction

    // next state: sequence advances on ms ticks only
    always_comb begin
        s_d = s_q;
        if (!s_q.active) begin
            // start on any cause, bus defect takes precedence
            if (bus_defect_i || node_bad_i) begin
                s_d.active = 1'b1;
                s_d.code   = !bus_defect_i;
                s_d.idx    = 3'h0;
                s_d.on     = 1'b1;
                s_d.cnt    = 12'h000;
            end
        end else if (tick_i) begin
            s_d.cnt = s_q.cnt + 12'h001;
            if (s_q.on) begin
                // end of a pulse
                if (s_d.cnt >= on_time(s_q.code, s_q.idx)) begin
                    s_d.on  = 1'b0;
                    s_d.cnt = 12'h000;
                end
            end else if (s_q.idx == RED_LAST_IDX) begin
                // long pause then repeat or stop; a code always plays out whole
                if (s_d.cnt >= RED_PAUSE_MS) begin
                    s_d.cnt = 12'h000;
                    s_d.idx = 3'h0;
                    if (bus_defect_i || node_bad_i) begin
                        s_d.code = !bus_defect_i;
                        s_d.on   = 1'b1;
                    end else begin
                        s_d.active = 1'b0;
                    end
                end
            end else if (s_d.cnt >= RED_GAP_MS) begin
                // short gap then next pulse
                s_d.cnt = 12'h000;
                s_d.idx = s_q.idx + 3'h1;
                s_d.on  = 1'b1;
            end
        end
        s_d.red = s_d.active && s_d.on;
    end

    // state register, idle after reset
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign red_o  = s_q.red;
    assign busy_o = s_q.active;

endmodule

/* File: logic/fieldbus_node_status_indicator.sv */
// node management state tracking and lamp patterns for a controlled node
// assumes all inputs synchronous to clk_sys_i; frame inputs are one-cycle pulses
`timescale 1ns/10ps
module fieldbus_node_status_indicator
    import fbn_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT  // clocks per ms tick
) (
    // clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        rst_b_i,
    // ethernet ports
    input  wire logic [1:0]  link_up_i,          // level, per port
    input  wire logic [1:0]  traffic_i,          // pulse per frame seen, per port
    // fieldbus events
    input  wire logic        fb_frame_i,         // any fieldbus frame, pulse
    input  wire logic        soc_frame_i,        // start-of-cycle frame, pulse
    input  wire nmt_cmd_s    nmt_cmd_i,          // manager command, valid is a pulse
    // configuration
    input  wire logic [15:0] na_timeout_ms_i,    // not-active timeout window
    input  wire logic [7:0]  node_id_i,          // configured node number
    // error causes, levels
    input  wire logic        mgr_fail_i,
    input  wire logic        iface_err_i,
    input  wire logic        bus_defect_i,
    input  wire logic        critical_fault_i,
    // lamps
    output logic             port_a_link_lamp_o,
    output logic             port_b_link_lamp_o,
    output logic             status_green_o,
    output logic             error_red_o,
    output logic             fault_lamp_o,
    // node state
    output nmt_state_e       nmt_state_o,
    output logic             pdo_tx_en_o,        // process data may be sent
    output logic             pdo_rx_eval_o       // received cyclic data is used
);

    top_st_s s_q;          // registered state
    top_st_s s_d;          // next state
    logic    seq_red;      // red code pattern, registered in sequencer
    logic    seq_busy;     // red code sequence running
    logic    node_bad;     // node number out of range

    // prescaler width limit: the tick count must fit TICK_W bits
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // flash count shown in each state, zero for non-flash patterns
    function automatic logic [1:0] flash_n(input nmt_state_e st);
        unique case (st)
            ST_PREOP1: flash_n = 2'h1;
            ST_PREOP2: flash_n = 2'h2;
            ST_READY:  flash_n = 2'h3;
            default:   flash_n = 2'h0;
        endcase
    endfunction

    // period of the green pattern in ms
    function automatic logic [11:0] g_period(input nmt_state_e st);
        logic [11:0] step;
        step = FLASH_ON_MS + FLASH_GAP_MS;
        unique case (st)
            ST_BASIC_ETH: g_period = FLICKER_HALF_MS + FLICKER_HALF_MS;
            ST_PREOP1,
            ST_PREOP2,
            ST_READY:     g_period = 12'({10'h000, flash_n(st)} * step)
                                     - FLASH_GAP_MS + FLASH_TAIL_MS;
            ST_STOPPED:   g_period = BLINK_HALF_MS + BLINK_HALF_MS;
            default:      g_period = 12'h001;
        endcase
    endfunction

    // green level for a state at a point in its period
    function automatic logic g_lit(input nmt_state_e st, input logic [11:0] c);
        logic [11:0] start;
        logic [11:0] step;
        logic        hit;
        step = FLASH_ON_MS + FLASH_GAP_MS;
        hit  = 1'b0;
        for (int k = 0; k < 3; k++) begin
            start = 12'(k) * step;
            if (k < int'(flash_n(st)) && c >= start && c < start + FLASH_ON_MS) begin
                hit = 1'b1;
            end
        end
        unique case (st)
            ST_NOT_ACTIVE: g_lit = 1'b0;
            ST_BASIC_ETH:  g_lit = (c < FLICKER_HALF_MS);
            ST_PREOP1:     g_lit = hit;
            ST_PREOP2:     g_lit = hit;
            ST_READY:      g_lit = hit;
            ST_OPER:       g_lit = 1'b1;
            ST_STOPPED:    g_lit = (c < BLINK_HALF_MS);
            default:       g_lit = 1'b0;
        endcase
    endfunction

    // states in which a manager failure lights red steady beside the green pattern; interface errors light red in any state
    function automatic logic pre_op_like(input nmt_state_e st);
        pre_op_like = (st == ST_BASIC_ETH) || (st == ST_PREOP1) ||
                      (st == ST_PREOP2)    || (st == ST_READY);
    endfunction

    // node numbers above the range are refused
    assign node_bad = (node_id_i > NODE_ID_MAX);

    // red error code generator
    red_code_seq u_red_seq (
        .clk_sys_i    (clk_sys_i),
        .rst_b_i      (rst_b_i),
        .tick_i       (s_q.tick),
        .bus_defect_i (bus_defect_i),
        .node_bad_i   (node_bad),
        .red_o        (seq_red),
        .busy_o       (seq_busy)
    );

    // next state of everything
    always_comb begin
        s_d = s_q;

        // ms tick prescaler; tick is a one-cycle pulse
        s_d.tick = 1'b0;
        if (s_q.tick_cnt >= TICK_LAST) begin
            s_d.tick_cnt = '0;
            s_d.tick     = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + TICK_W'(1);
        end

        // node management transitions
        unique case (s_q.nmt)
            ST_NOT_ACTIVE: begin
                // frame wins over a timeout landing in the same cycle
                if (fb_frame_i) begin
                    s_d.nmt = ST_PREOP1;
                end else if (s_q.tick) begin
                    s_d.na_cnt = s_q.na_cnt + 16'h0001;
                    if (s_d.na_cnt >= na_timeout_ms_i) begin
                        s_d.nmt = ST_BASIC_ETH;
                    end
                end
            end
            ST_BASIC_ETH: begin
                if (fb_frame_i) begin
                    s_d.nmt = ST_PREOP1;
                end
            end
            ST_PREOP1: begin
                if (soc_frame_i) begin
                    s_d.nmt = ST_PREOP2;
                end
            end
            ST_PREOP2: begin
                // the manager configures, then commands ready
                if (nmt_cmd_i.valid && nmt_cmd_i.cmd == CMD_READY) begin
                    s_d.nmt = ST_READY;
                end
            end
            ST_READY: begin
                if (nmt_cmd_i.valid && nmt_cmd_i.cmd == CMD_START) begin
                    s_d.nmt = ST_OPER;
                end
            end
            ST_OPER: begin
                // leaving operational needs a command below
            end
            ST_STOPPED: begin
                // only a manager command leaves stopped
                if (nmt_cmd_i.valid && nmt_cmd_i.cmd == CMD_PREOP2) begin
                    s_d.nmt = ST_PREOP2;
                end
            end
            default: begin
                s_d.nmt = ST_NOT_ACTIVE;                               // illegal code
            end
        endcase

        // commands valid from several states
        if (nmt_cmd_i.valid && nmt_cmd_i.cmd == CMD_STOP &&
            (s_q.nmt == ST_PREOP2 || s_q.nmt == ST_READY || s_q.nmt == ST_OPER)) begin
            s_d.nmt = ST_STOPPED;
        end
        if (nmt_cmd_i.valid && nmt_cmd_i.cmd == CMD_RESET) begin
            s_d.nmt = ST_NOT_ACTIVE;
        end
        if (s_d.nmt != ST_NOT_ACTIVE) begin
            s_d.na_cnt = 16'h0000;                                     // fresh window next time
        end

        // green pattern phase restarts on every state change
        if (s_d.nmt != s_q.nmt) begin
            s_d.g_cnt = 12'h000;
        end else if (s_q.tick) begin
            if (s_q.g_cnt + 12'h001 >= g_period(s_q.nmt)) begin
                s_d.g_cnt = 12'h000;
            end else begin
                s_d.g_cnt = s_q.g_cnt + 12'h001;
            end
        end

        // link lamps: steady with link, toggling while traffic is recent
        for (int p = 0; p < 2; p++) begin
            if (traffic_i[p]) begin
                s_d.act_cnt[p] = ACT_HOLD_MS;
            end else if (s_q.tick && s_q.act_cnt[p] != 12'h000) begin
                s_d.act_cnt[p] = s_q.act_cnt[p] - 12'h001;
            end
            if (s_q.tick) begin
                s_d.ph_cnt[p] = (s_q.ph_cnt[p] + 12'h001 >= ACT_HALF_MS + ACT_HALF_MS) ?
                                12'h000 : s_q.ph_cnt[p] + 12'h001;
            end
            if (!link_up_i[p]) begin
                s_d.lamp.link[p] = 1'b0;
            end else if (s_q.act_cnt[p] != 12'h000) begin
                s_d.lamp.link[p] = (s_q.ph_cnt[p] < ACT_HALF_MS);
            end else begin
                s_d.lamp.link[p] = 1'b1;
            end
        end

        // green carries the state pattern regardless of red
        s_d.lamp.green = g_lit(s_d.nmt, s_d.g_cnt);

        // red: error code first, then steady faults; green stays on top
        if (seq_busy) begin
            s_d.lamp.red = seq_red;
        end else if (mgr_fail_i && pre_op_like(s_q.nmt)) begin
            s_d.lamp.red = 1'b1;
        end else begin
            s_d.lamp.red = iface_err_i;
        end

        // critical failure lamp follows the fault level
        s_d.lamp.fault = critical_fault_i;

        // process data handling per state
        s_d.pdo_tx = (s_d.nmt == ST_READY) || (s_d.nmt == ST_OPER);
        s_d.pdo_rx = (s_d.nmt == ST_OPER);
    end

    // state register; reset leaves not-active with every lamp dark
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q <= '{nmt: ST_NOT_ACTIVE, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign port_a_link_lamp_o = s_q.lamp.link[0];
    assign port_b_link_lamp_o = s_q.lamp.link[1];
    assign status_green_o     = s_q.lamp.green;
    assign error_red_o        = s_q.lamp.red;
    assign fault_lamp_o       = s_q.lamp.fault;
    assign nmt_state_o        = s_q.nmt;
    assign pdo_tx_en_o        = s_q.pdo_tx;
    assign pdo_rx_eval_o      = s_q.pdo_rx;

endmodule

/* File: dv/mgr_node_model.sv */
// managing node model: sends fieldbus frames and manager commands
// assumes the bench calls send() and the node samples on rising edges
`timescale 1ns/10ps
module mgr_node_model
    import fbn_pkg::*;
(
    // clock
    input  wire logic clk_sys_i,
    // events towards the node
    output logic      fb_frame_o,
    output logic      soc_frame_o,
    output nmt_cmd_s  nmt_cmd_o
);
    // quiet at time zero
    initial begin
        fb_frame_o  = 1'b0;
        soc_frame_o = 1'b0;
        nmt_cmd_o   = '0;
    end
    // ev 8 frame, 9 start-of-cycle, else a command code
    // gap lets the manager answer slowly; each event is one cycle wide
    task automatic send(input int ev, input int gap);
        repeat (gap + 1) @(negedge clk_sys_i);
        fb_frame_o  = (ev == 8);
        soc_frame_o = (ev == 9);
        nmt_cmd_o   = '{valid: (ev < 8), cmd: nmt_cmd_e'(ev[2:0])};
        @(negedge clk_sys_i);
        fb_frame_o  = 1'b0;
        soc_frame_o = 1'b0;
        nmt_cmd_o   = '0;
    endtask
endmodule

/* File: dv/fbn_sva.sv */
// checker for state and lamp relations seen at the top ports
// assumes it is bound into fieldbus_node_status_indicator, one clock
`timescale 1ns/10ps
module fbn_sva
    import fbn_pkg::*;
(
    // clock and reset
    input wire logic       clk_sys_i,
    input wire logic       rst_b_i,
    // watched inputs
    input wire logic [1:0] link_up_i,
    input wire logic       fb_frame_i,
    input wire logic       soc_frame_i,
    input wire nmt_cmd_s   nmt_cmd_i,
    input wire logic       critical_fault_i,
    // watched outputs
    input wire logic       port_a_link_lamp_o,
    input wire logic       status_green_o,
    input wire logic       fault_lamp_o,
    input wire nmt_state_e nmt_state_o,
    input wire logic       pdo_tx_en_o,
    input wire logic       pdo_rx_eval_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // a reset command outranks a frame in the same cycle, so frames are checked with no command valid
    wire logic cmd_v = nmt_cmd_i.valid;

    property p_fault; $past(rst_b_i) |-> fault_lamp_o == $past(critical_fault_i); endproperty
    a_fault: assert property (p_fault) else $error("fault lamp lag");
    property p_link_off; !link_up_i[0] |=> !port_a_link_lamp_o; endproperty
    a_link_off: assert property (p_link_off) else $error("link lamp lit");
    property p_pdo_tx; pdo_tx_en_o == (nmt_state_o inside {ST_READY, ST_OPER}); endproperty
    a_pdo_tx: assert property (p_pdo_tx) else $error("tx enable wrong");
    property p_pdo_rx; pdo_rx_eval_o == (nmt_state_o == ST_OPER); endproperty
    a_pdo_rx: assert property (p_pdo_rx) else $error("rx eval wrong");
    property p_oper; nmt_state_o == ST_OPER |-> status_green_o; endproperty
    a_oper: assert property (p_oper) else $error("green off in oper");
    property p_na; nmt_state_o == ST_NOT_ACTIVE |-> !status_green_o; endproperty
    a_na: assert property (p_na) else $error("green on in not-active");
    property p_frame;
        nmt_state_o == ST_NOT_ACTIVE && fb_frame_i && !cmd_v |=> nmt_state_o == ST_PREOP1;
    endproperty
    a_frame: assert property (p_frame) else $error("frame ignored");
    property p_soc;
        nmt_state_o == ST_PREOP1 && soc_frame_i && !cmd_v |=> nmt_state_o == ST_PREOP2;
    endproperty
    a_soc: assert property (p_soc) else $error("soc ignored");
    property p_stop_hold; nmt_state_o == ST_STOPPED && !cmd_v |=> $stable(nmt_state_o); endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped left alone");
    property p_rst_cmd;
        cmd_v && nmt_cmd_i.cmd == CMD_RESET |=> nmt_state_o == ST_NOT_ACTIVE;
    endproperty
    a_rst_cmd: assert property (p_rst_cmd) else $error("reset command ignored");
    // main scenarios reached
    c_oper: cover property (nmt_state_o == ST_OPER);
    c_stop: cover property (nmt_state_o == ST_STOPPED);
    c_fault: cover property (fault_lamp_o);
endmodule

bind fieldbus_node_status_indicator fbn_sva u_sva (
    .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_up_i(link_up_i),
    .fb_frame_i(fb_frame_i), .soc_frame_i(soc_frame_i), .nmt_cmd_i(nmt_cmd_i),
    .critical_fault_i(critical_fault_i), .port_a_link_lamp_o(port_a_link_lamp_o),
    .status_green_o(status_green_o), .fault_lamp_o(fault_lamp_o),
    .nmt_state_o(nmt_state_o), .pdo_tx_en_o(pdo_tx_en_o), .pdo_rx_eval_o(pdo_rx_eval_o)
);

/* File: dv/tb_fieldbus_node_status_indicator.sv */
// self-checking bench for the node status indicator
// assumes TICK_CYCLES of 10, so one ms is ten clocks
`timescale 1ns/10ps
module tb_fieldbus_node_status_indicator;
    import fbn_pkg::*;
    // stimulus and observed signals
    logic clk_sys_i, rst_b_i, fb_frame_i, soc_frame_i, mgr_fail_i, iface_err_i;
    logic bus_defect_i, critical_fault_i, port_a_link_lamp_o, port_b_link_lamp_o;
    logic status_green_o, error_red_o, fault_lamp_o, pdo_tx_en_o, pdo_rx_eval_o;
    logic [1:0]  link_up_i, traffic_i;
    logic [15:0] na_timeout_ms_i;
    logic [7:0]  node_id_i;
    nmt_cmd_s    nmt_cmd_i;
    nmt_state_e  nmt_state_o;
    int mismatches = 0, n_tests = 0, hi, lo;
    // table rows: event beside the state it should give
    int ev_t [11] = '{0, 8, 9, 2, 1, 2, 3, 9, 4, 1, 5};
    nmt_state_e st_t [11] = '{ST_NOT_ACTIVE, ST_PREOP1, ST_PREOP2, ST_PREOP2, ST_READY,
        ST_OPER, ST_STOPPED, ST_STOPPED, ST_PREOP2, ST_READY, ST_NOT_ACTIVE};
    // red on-times and off-times in clocks
    int dh [4] = '{6000, 1500, 1500, 1500};
    int dl [4] = '{1500, 1500, 1500, 20000};
    int nh [2] = '{1500, 6000};

    fieldbus_node_status_indicator #(.TICK_CYCLES(10)) dut (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link_up_i(link_up_i),
        .traffic_i(traffic_i), .fb_frame_i(fb_frame_i), .soc_frame_i(soc_frame_i),
        .nmt_cmd_i(nmt_cmd_i), .na_timeout_ms_i(na_timeout_ms_i), .node_id_i(node_id_i),
        .mgr_fail_i(mgr_fail_i), .iface_err_i(iface_err_i), .bus_defect_i(bus_defect_i),
        .critical_fault_i(critical_fault_i), .port_a_link_lamp_o(port_a_link_lamp_o),
        .port_b_link_lamp_o(port_b_link_lamp_o), .status_green_o(status_green_o),
        .error_red_o(error_red_o), .fault_lamp_o(fault_lamp_o), .nmt_state_o(nmt_state_o),
        .pdo_tx_en_o(pdo_tx_en_o), .pdo_rx_eval_o(pdo_rx_eval_o));
    mgr_node_model mgr (.clk_sys_i(clk_sys_i), .fb_frame_o(fb_frame_i),
        .soc_frame_o(soc_frame_i), .nmt_cmd_o(nmt_cmd_i));

    // 10 mhz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // verdict, the single exit point
    task automatic test_done();
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // compare tasks, one per kind of result
    task automatic chk_bit(input logic g, input logic e);
        n_tests++;
        if (g !== e) begin mismatches++; $display("ERROR %0t lamp/flag %b not %b", $time, g, e); end
    endtask
    task automatic chk_st(input nmt_state_e g, input nmt_state_e e);
        n_tests++;
        if (g !== e) begin mismatches++; $display("ERROR %0t state %0d not %0d", $time, g, e); end
    endtask
    task automatic chk_int(input int g, input int e);
        n_tests++;
        if (g != e) begin mismatches++; $display("ERROR %0t span %0d not %0d", $time, g, e); end
    endtask
    function automatic logic sig(input int s);
        return (s == 0) ? status_green_o : (s == 1) ? error_red_o : port_a_link_lamp_o;
    endfunction
    // measure one on run and the following off run; fresh skips a partial run
    task automatic pulse(input int s, input bit fresh, output int h, output int l);
        int k;
        k = 0;
        h = 0;
        l = 0;
        while (fresh && sig(s) !== 1'b0 && k < 30000) begin @(negedge clk_sys_i); k++; end
        while (sig(s) !== 1'b1 && k < 30000) begin @(negedge clk_sys_i); k++; end
        while (sig(s) === 1'b1 && h < 30000) begin @(negedge clk_sys_i); h++; end
        while (sig(s) === 1'b0 && l < 30000) begin @(negedge clk_sys_i); l++; end
    endtask
    // reset held twelve clocks, released off the sampling edge
    task automatic do_reset();
        rst_b_i = 1'b0;
        repeat (12) @(negedge clk_sys_i);
        rst_b_i = 1'b1;
    endtask
    // watchdog sized above the longest expected run
    initial begin
        #9_500_000;
        mismatches++;
        test_done();
    end

    initial begin
        {link_up_i, traffic_i, mgr_fail_i, iface_err_i, bus_defect_i, critical_fault_i} = '0;
        na_timeout_ms_i = 16'hffff;
        node_id_i       = 8'h05;
        do_reset();
        chk_st(nmt_state_o, ST_NOT_ACTIVE);
        chk_bit(error_red_o, 1'b0);
        // ordinary transitions, some refused, every command code at least once
        for (int i = 0; i < 11; i++) begin
            mgr.send(ev_t[i], (i % 2) * 3);
            @(negedge clk_sys_i);
            chk_st(nmt_state_o, st_t[i]);
            chk_bit(pdo_tx_en_o, st_t[i] inside {ST_READY, ST_OPER});
        end
        // timeout of three ticks ends the not-active wait
        na_timeout_ms_i = 16'h0003;
        do_reset();
        repeat (25) @(negedge clk_sys_i);
        chk_st(nmt_state_o, ST_NOT_ACTIVE);
        repeat (15) @(negedge clk_sys_i);
        chk_st(nmt_state_o, ST_BASIC_ETH);
        pulse(0, 1, hi, lo);
        chk_int(hi, 500);
        chk_int(lo, 500);
        mgr_fail_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(error_red_o, 1'b1);
        mgr.send(8, 0);
        @(negedge clk_sys_i);
        chk_st(nmt_state_o, ST_PREOP1);
        chk_bit(error_red_o, 1'b1);
        mgr_fail_i = 1'b0;
        pulse(0, 1, hi, lo);
        chk_int(hi, 2000);
        chk_int(lo, 10000);
        mgr.send(9, 0);
        // the first flash is already lit; the gap after it is tick-aligned
        pulse(0, 0, hi, lo);
        chk_int(lo, 2000);
        mgr.send(1, 0);
        mgr.send(2, 0);
        iface_err_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(error_red_o, 1'b1);
        chk_bit(status_green_o, 1'b1);
        {iface_err_i, mgr_fail_i, critical_fault_i} = 3'h3;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(error_red_o, 1'b0);
        chk_bit(fault_lamp_o, 1'b1);
        {mgr_fail_i, critical_fault_i} = 2'h0;
        mgr.send(3, 0);
        pulse(0, 1, hi, lo);
        chk_int(hi, 2000);
        chk_int(lo, 2000);
        // link lamps: steady with link, blinking under traffic, dark without
        link_up_i = 2'h3;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(port_a_link_lamp_o, 1'b1);
        traffic_i = 2'h1;
        pulse(2, 1, hi, lo);
        chk_int(hi, 500);
        chk_int(lo, 500);
        chk_bit(port_b_link_lamp_o, 1'b1);
        {link_up_i, traffic_i} = 4'h2;
        repeat (3) @(negedge clk_sys_i);
        chk_bit(port_a_link_lamp_o, 1'b0);
        // highest valid node number leaves red dark
        node_id_i = 8'hef;
        do_reset();
        for (int i = 0; i < 30; i++) begin
            repeat (100) @(negedge clk_sys_i);
            chk_bit(error_red_o, 1'b0);
        end
        // first invalid node number
        node_id_i = 8'hf0;
        do_reset();
        for (int i = 0; i < 2; i++) begin
            pulse(1, i == 0, hi, lo);
            chk_int(hi, nh[i]);
        end
        // bus defect code, then the pause before it repeats
        node_id_i    = 8'h05;
        bus_defect_i = 1'b1;
        do_reset();
        for (int i = 0; i < 4; i++) begin
            pulse(1, i == 0, hi, lo);
            chk_int(hi, dh[i]);
            chk_int(lo, dl[i]);
        end
        test_done();
    end
endmodule
